// ==== hw/dtmf_pkg.sv ====
// Purpose: Shared constants for the dual-tone steering and tone burst core.
// Assumes: 10 MHz system clock; AHB-Lite register access with 32-bit words.
// Notes: Register offsets and control bit positions are local choices.
package dtmf_pkg;
  localparam int CLK_HZ = 10000000;
  localparam int SEGMENTS = 32;
  localparam logic [7:0] ADDR_RXDATA = 8'h00;
  localparam logic [7:0] ADDR_TXDATA = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_GUARD_PRESENT = 8'h10;
  localparam logic [7:0] ADDR_GUARD_ABSENT = 8'h14;
  localparam int CTRL_TX_ENABLE = 0;
  localparam int CTRL_CALL_PROGRESS = 1;
  localparam int CTRL_IRQ_ENABLE = 2;
  localparam int CTRL_BURST_ENABLE = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam int STAT_IRQ_PENDING = 0;
  localparam int STAT_TX_READY = 1;
  localparam int STAT_RX_FULL = 2;
  localparam int STAT_DELAYED_STEER = 3;
  localparam int GUARD_W = 24;
  localparam int GUARD_PRESENT_US = 20000;
  localparam int GUARD_ABSENT_US = 20000;
  localparam logic [GUARD_W-1:0] GUARD_PRESENT_RESET = GUARD_W'(GUARD_PRESENT_US * (CLK_HZ / 1000000));
  localparam logic [GUARD_W-1:0] GUARD_ABSENT_RESET = GUARD_W'(GUARD_ABSENT_US * (CLK_HZ / 1000000));
  localparam int SETTLE_NS = 1000;
  localparam int SETTLE_CYCLES = (SETTLE_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int BURST_MS = 51;
  localparam int BURST_CP_MS = 102;
  localparam int BURST_W = 21;
  localparam int LOW_HZ_0 = 697;
  localparam int LOW_HZ_1 = 770;
  localparam int LOW_HZ_2 = 852;
  localparam int LOW_HZ_3 = 941;
  localparam int HIGH_HZ_0 = 1209;
  localparam int HIGH_HZ_1 = 1336;
  localparam int HIGH_HZ_2 = 1477;
  localparam int HIGH_HZ_3 = 1633;
  localparam int DIV_W = 9;
  localparam int SAMPLE_W = 8;

  // Segment length in clocks for one thirty-second of a tone period, rounded.
  function automatic logic [DIV_W-1:0] seg_len(input int hz);
    seg_len = DIV_W'((CLK_HZ + 16 * hz) / (SEGMENTS * hz));
  endfunction : seg_len

  // Digit code to 2-of-8 form: high nibble one-hot column, low nibble one-hot row.
  function automatic logic [7:0] two_of_eight(input logic [3:0] code);
    logic [1:0] row;
    logic [1:0] col;
    row = 2'd3;
    col = 2'd3;
    if (code >= 4'd1 && code <= 4'd9) begin
      row = 2'((code - 4'd1) / 4'd3);
      col = 2'((code - 4'd1) % 4'd3);
    end else if (code == 4'd10) begin
      col = 2'd1;
    end else if (code == 4'd11) begin
      col = 2'd0;
    end else if (code == 4'd12) begin
      col = 2'd2;
    end else if (code >= 4'd13) begin
      row = 2'(code - 4'd13);
    end
    two_of_eight = {4'(4'h1 << col), 4'(4'h1 << row)};
  endfunction : two_of_eight

  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_TONE = 3'b010,
    TX_PAUSE = 3'b100
  } tx_state_e;
endpackage : dtmf_pkg

// ==== hw/sine_rom.sv ====
// Purpose: Two-port sine table for the row and column tone paths.
// Assumes: 32 entries per period, unsigned samples centred on 8'h80.
// Notes: Read data is registered, so it trails the address by one clock.
`timescale 1ns/1ps
module sine_rom
  import dtmf_pkg::*;
(
  input wire logic clk, // System clock.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic [4:0] addr_a, // Row path address.
  input wire logic [4:0] addr_b, // Column path address.
  output logic [SAMPLE_W-1:0] data_a, // Row path sample.
  output logic [SAMPLE_W-1:0] data_b // Column path sample.
);
  // Quarter-wave table; the rest of the period is mirrored from it.
  function automatic logic [SAMPLE_W-1:0] sine_at(input logic [4:0] a);
    logic [2:0] q;
    logic [6:0] mag;
    q = a[3] ? 3'(4'h8 - {1'b0, a[2:0]}) : a[2:0];
    case (a[3] && a[2:0] == 3'h0 ? 4'h8 : {1'b0, q})
      4'h0: mag = 7'h00;
      4'h1: mag = 7'h19;
      4'h2: mag = 7'h31;
      4'h3: mag = 7'h47;
      4'h4: mag = 7'h5A;
      4'h5: mag = 7'h6A;
      4'h6: mag = 7'h76;
      4'h7: mag = 7'h7D;
      default: mag = 7'h7F;
    endcase
    sine_at = a[4] ? SAMPLE_W'(8'h80 - {1'b0, mag}) : SAMPLE_W'(8'h80 + {1'b0, mag});
  endfunction : sine_at

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      data_a <= 8'h80;
      data_b <= 8'h80;
    end else begin
      data_a <= sine_at(addr_a);
      data_b <= sine_at(addr_b);
    end
  end
endmodule : sine_rom

// ==== hw/dtmf_core.sv ====
// Purpose: Receive steering, status and interrupt pin, and tone burst generator behind AHB-Lite.
// Assumes: Detector, comparator and call progress inputs are synchronous to clk.
// Notes: Zero-wait-state slave; a status read clears the receive-full, ready and interrupt flags.
//
// Our own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
module dtmf_core
  import dtmf_pkg::*;
#(
  parameter int BURST_CYCLES = BURST_MS * (CLK_HZ / 1000),
  parameter int BURST_CP_CYCLES = BURST_CP_MS * (CLK_HZ / 1000)
) (
  input wire logic clk, // System clock, 10 MHz.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic hsel, // AHB slave select.
  input wire logic [31:0] haddr, // AHB address.
  input wire logic [1:0] htrans, // AHB transfer type.
  input wire logic hwrite, // AHB write strobe.
  input wire logic [2:0] hsize, // AHB transfer size, words only.
  input wire logic [31:0] hwdata, // AHB write data.
  input wire logic hready, // AHB bus ready.
  output logic [31:0] hrdata, // AHB read data.
  output logic hreadyout, // AHB slave ready.
  output logic hresp, // AHB response, always OKAY.
  input wire logic tones_valid, // Detector sees two valid tones.
  input wire logic [3:0] det_code, // Detector digit code.
  input wire logic cp_square, // Hard-limited call progress comparator output.
  input wire logic cp_inband, // Call progress input lies in the accept band.
  output logic early_steer, // Early steering output.
  output logic guard_drive_out, // Guard time drive level for the steering pin.
  output logic guard_oe_n, // Steering pin drive enable, active low.
  output logic [3:0] rx_code_bits, // Latched receive code.
  output logic interrupt_or_tone_out, // Shared interrupt or call progress pin level.
  output logic interrupt_or_tone_oe_n, // Shared pin pull-down enable, active low.
  output logic [SAMPLE_W:0] tone_sample, // Summed row and column samples.
  output logic tone_active // Transmitter is emitting a tone.
);
  logic [3:0] ctrl;
  logic [GUARD_W-1:0] tone_present_guard;
  logic [GUARD_W-1:0] tone_absent_guard;
  logic [3:0] tx_code;
  logic [7:0] tx_two_of_eight;
  logic held;
  logic dsteer;
  logic [GUARD_W-1:0] steer_cnt;
  logic [3:0] settle_cnt;
  logic [3:0] code_cap;
  logic rx_full;
  logic irq_pend;
  logic tx_ready;
  logic wr_pend;
  logic [7:0] wr_addr;
  tx_state_e tx_state;
  tx_state_e next_tx_state;
  logic [BURST_W-1:0] tx_cnt;
  logic [DIV_W-1:0] row_div;
  logic [DIV_W-1:0] col_div;
  logic [4:0] row_addr;
  logic [4:0] col_addr;
  logic [SAMPLE_W-1:0] row_sample;
  logic [SAMPLE_W-1:0] col_sample;

  // Bus decode.
  wire call_progress_mode = ctrl[CTRL_CALL_PROGRESS];
  wire tx_enable = ctrl[CTRL_TX_ENABLE];
  wire burst_enable = ctrl[CTRL_BURST_ENABLE];
  wire irq_enable = ctrl[CTRL_IRQ_ENABLE];
  wire addr_ok = hsel && htrans[1] && hready;
  wire rd_take = addr_ok && !hwrite;
  wire status_read = rd_take && haddr[7:0] == ADDR_STATUS && haddr[31:8] == 24'h0;
  wire wr_tx = wr_pend && wr_addr == ADDR_TXDATA;
  wire [3:0] status_word = {dsteer, rx_full, tx_ready, irq_pend};
  assign tx_two_of_eight = two_of_eight(tx_code);
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0;
    if (haddr[31:8] != 24'h0) begin
      rd_word = 32'h0;
    end else if (haddr[7:0] == ADDR_RXDATA) begin
      rd_word = {28'h0, rx_code_bits};
    end else if (haddr[7:0] == ADDR_CTRL) begin
      rd_word = {28'h0, ctrl};
    end else if (haddr[7:0] == ADDR_STATUS) begin
      rd_word = {28'h0, status_word};
    end else if (haddr[7:0] == ADDR_GUARD_PRESENT) begin
      rd_word = {8'h0, tone_present_guard};
    end else if (haddr[7:0] == ADDR_GUARD_ABSENT) begin
      rd_word = {8'h0, tone_absent_guard};
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend <= 1'b0;
      wr_addr <= 8'h0;
    end else begin
      wr_pend <= addr_ok && hwrite && haddr[31:8] == 24'h0;
      wr_addr <= haddr[7:0];
      if (rd_take) begin
        hrdata <= rd_word;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= CTRL_RESET;
      tone_present_guard <= GUARD_PRESENT_RESET;
      tone_absent_guard <= GUARD_ABSENT_RESET;
      tx_code <= 4'h0;
    end else if (wr_pend) begin
      if (wr_addr == ADDR_CTRL) begin
        ctrl <= hwdata[3:0];
      end else if (wr_addr == ADDR_GUARD_PRESENT) begin
        tone_present_guard <= hwdata[GUARD_W-1:0];
      end else if (wr_addr == ADDR_GUARD_ABSENT) begin
        tone_absent_guard <= hwdata[GUARD_W-1:0];
      end else if (wr_addr == ADDR_TXDATA) begin
        tx_code <= hwdata[3:0];
      end
    end
  end

  // Receive steering. The guard counter stands in for the external RC network.
  wire next_early = tones_valid && !call_progress_mode;
  wire [GUARD_W-1:0] cnt_inc = GUARD_W'(steer_cnt + 1'b1);
  wire steer_threshold = !held ? (early_steer && cnt_inc >= tone_present_guard)
                               : (!early_steer && cnt_inc >= tone_absent_guard);
  wire settle_done = held && !dsteer && settle_cnt == 4'(SETTLE_CYCLES - 1);
  wire dsteer_rise = settle_done && early_steer;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      early_steer <= 1'b0;
      held <= 1'b0;
      steer_cnt <= '0;
      code_cap <= 4'h0;
      settle_cnt <= 4'h0;
      dsteer <= 1'b0;
      rx_code_bits <= 4'h0;
      guard_drive_out <= 1'b0;
      guard_oe_n <= 1'b0;
    end else begin
      early_steer <= next_early;
      guard_drive_out <= held && !steer_threshold && next_early;
      if (steer_threshold) begin
        held <= !held;
        steer_cnt <= '0;
      end else if (held == early_steer) begin
        steer_cnt <= '0;
      end else begin
        steer_cnt <= cnt_inc;
      end
      if (!held && steer_threshold) begin
        code_cap <= det_code;
      end
      if (!held || dsteer) begin
        settle_cnt <= 4'h0;
      end else if (!settle_done) begin
        settle_cnt <= settle_cnt + 4'h1;
      end
      if (dsteer_rise) begin
        dsteer <= 1'b1;
        rx_code_bits <= code_cap;
      end else if (held && steer_threshold) begin
        dsteer <= 1'b0;
      end
    end
  end

  // Burst timing; the status flags below read tx_done.
  wire [BURST_W-1:0] burst_len = call_progress_mode ? BURST_W'(BURST_CP_CYCLES) : BURST_W'(BURST_CYCLES);
  wire burst_end = tx_cnt == BURST_W'(burst_len - 1'b1);
  wire tx_done = tx_state == TX_PAUSE && burst_end && tx_enable && burst_enable;

  // Status flags; a new event wins over the clearing status read.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_full <= 1'b0;
      irq_pend <= 1'b0;
      tx_ready <= 1'b0;
      interrupt_or_tone_out <= 1'b0;
      interrupt_or_tone_oe_n <= 1'b1;
    end else begin
      rx_full <= dsteer_rise || (rx_full && !status_read);
      irq_pend <= dsteer_rise || tx_done || (irq_pend && !status_read);
      tx_ready <= tx_done || (tx_ready && !status_read);
      if (call_progress_mode) begin
        interrupt_or_tone_oe_n <= cp_square && cp_inband;
      end else begin
        interrupt_or_tone_oe_n <= !(irq_enable && irq_pend);
      end
    end
  end

  // Transmit burst sequencer.
  always_comb begin
    next_tx_state = tx_state;
    case (tx_state)
      TX_IDLE: begin
        if (tx_enable && (!burst_enable || wr_tx)) begin
          next_tx_state = TX_TONE;
        end
      end
      TX_TONE: begin
        if (!tx_enable) begin
          next_tx_state = TX_IDLE;
        end else if (burst_enable && burst_end) begin
          next_tx_state = TX_PAUSE;
        end
      end
      TX_PAUSE: begin
        if (!tx_enable || burst_end) begin
          next_tx_state = TX_IDLE;
        end
      end
      default: next_tx_state = TX_IDLE;
    endcase
  end

  // Row and column dividers, each stepping its own sine address.
  wire [DIV_W-1:0] row_limit = tx_two_of_eight[0] ? seg_len(LOW_HZ_0) : tx_two_of_eight[1] ? seg_len(LOW_HZ_1)
                             : tx_two_of_eight[2] ? seg_len(LOW_HZ_2) : seg_len(LOW_HZ_3);
  wire [DIV_W-1:0] col_limit = tx_two_of_eight[4] ? seg_len(HIGH_HZ_0) : tx_two_of_eight[5] ? seg_len(HIGH_HZ_1)
                             : tx_two_of_eight[6] ? seg_len(HIGH_HZ_2) : seg_len(HIGH_HZ_3);
  wire row_wrap = row_div >= DIV_W'(row_limit - 1'b1);
  wire col_wrap = col_div >= DIV_W'(col_limit - 1'b1);
  wire tone_on = tx_state == TX_TONE;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_state <= TX_IDLE;
      tx_cnt <= '0;
      row_div <= '0;
      col_div <= '0;
      row_addr <= 5'h0;
      col_addr <= 5'h0;
      tone_active <= 1'b0;
      tone_sample <= 9'h100;
    end else begin
      tx_state <= next_tx_state;
      tx_cnt <= (next_tx_state != tx_state) ? '0 : BURST_W'(tx_cnt + 1'b1);
      if (!tone_on) begin
        row_div <= '0;
        col_div <= '0;
        row_addr <= 5'h0;
        col_addr <= 5'h0;
      end else begin
        row_div <= row_wrap ? '0 : DIV_W'(row_div + 1'b1);
        col_div <= col_wrap ? '0 : DIV_W'(col_div + 1'b1);
        row_addr <= row_wrap ? 5'(row_addr + 1'b1) : row_addr;
        col_addr <= col_wrap ? 5'(col_addr + 1'b1) : col_addr;
      end
      tone_active <= tone_on;
      tone_sample <= tone_active ? (SAMPLE_W + 1)'(row_sample + col_sample) : 9'h100;
    end
  end

  sine_rom rom (
    .clk(clk),
    .nrst(nrst),
    .addr_a(row_addr),
    .addr_b(col_addr),
    .data_a(row_sample),
    .data_b(col_sample)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_registered;
    !held ##1 held;
  endsequence
  sequence s_settled;
    !dsteer [*8];
  endsequence
  chk_early_follow: assert property (tones_valid && !call_progress_mode |=> early_steer)
    else $error("early steer missed valid tones");
  chk_cp_blocks_rx: assert property (call_progress_mode |=> !early_steer ##1 !(!held && steer_threshold))
    else $error("tone registered in call progress mode");
  chk_guard_hold: assert property (held && dsteer && early_steer && tones_valid && !call_progress_mode
                                   |=> guard_drive_out)
    else $error("guard drive dropped while steering held");
  chk_settle_delay: assert property (s_registered |-> s_settled)
    else $error("delayed steering rose too early");
  chk_rx_latch: assert property ($rose(dsteer) |-> rx_code_bits == $past(code_cap) && rx_full)
    else $error("receive latch not updated with delayed steering");
  chk_dropout_keep: assert property (dsteer && early_steer |=> dsteer && $stable(rx_code_bits))
    else $error("short dropout changed receive state");
  chk_status_clear: assert property (status_read && !dsteer_rise && !tx_done |=> !rx_full && !irq_pend)
    else $error("status read did not clear flags");
  chk_irq_pin: assert property (!call_progress_mode && irq_enable && irq_pend |=> !interrupt_or_tone_oe_n)
    else $error("interrupt pin not pulled low");
  chk_cp_reject: assert property (call_progress_mode && !cp_inband |=> !interrupt_or_tone_oe_n)
    else $error("call progress pin not low in reject band");
  chk_burst_length: assert property (tx_state == TX_TONE && next_tx_state == TX_PAUSE
                                     |-> tx_cnt == BURST_W'(burst_len - 1'b1))
    else $error("burst length wrong");
  chk_ready_after: assert property (tx_done |=> tx_ready && tx_state == TX_IDLE)
    else $error("ready not set after burst and pause");

  // Receive path checks.
  chk_early_drop: assert property (!tones_valid || call_progress_mode |=> !early_steer)
    else $error("early steer stayed high without valid tones");
  chk_code_capture: assert property (!held && steer_threshold |=> held && code_cap == $past(det_code))
    else $error("tone pair not registered at the threshold");
  chk_guard_release: assert property (!tones_valid || call_progress_mode |=> !guard_drive_out)
    else $error("guard drive high without early steering");
  chk_settle_hold: assert property (held && !dsteer && settle_cnt != 4'(SETTLE_CYCLES - 1)
                                    |=> !dsteer)
    else $error("delayed steering rose before the settle count");
  chk_rx_hold: assert property (!dsteer_rise |=> $stable(rx_code_bits))
    else $error("receive latch changed without delayed steering");
  chk_pause_drop: assert property (held && steer_threshold |=> !held && !dsteer)
    else $error("valid pause did not free the steering logic");
  chk_full_set: assert property (dsteer_rise |=> rx_full && irq_pend)
    else $error("receive full or interrupt flag not set");
  chk_irq_release: assert property (!call_progress_mode && !(irq_enable && irq_pend)
                                    |=> interrupt_or_tone_oe_n)
    else $error("interrupt pin held low without a pending interrupt");
  chk_cp_square: assert property (call_progress_mode && cp_inband
                                  |=> interrupt_or_tone_oe_n == $past(cp_square))
    else $error("call progress pin does not follow the square wave");

  // Transmit path checks.
  sequence s_tone_begins;
    tx_state == TX_TONE ##1 tone_active;
  endsequence
  chk_code_form: assert property ($onehot(tx_two_of_eight[3:0]) && $onehot(tx_two_of_eight[7:4]))
    else $error("transmit code not in two of eight form");
  chk_burst_start: assert property (tx_state == TX_IDLE && tx_enable && burst_enable && wr_tx
                                    |=> s_tone_begins)
    else $error("burst did not start after a transmit write");
  chk_row_step: assert property (tone_on && !row_wrap |=> $stable(row_addr))
    else $error("row address moved inside a segment");
  chk_col_step: assert property (tone_on && !col_wrap |=> $stable(col_addr))
    else $error("column address moved inside a segment");
  chk_silent: assert property (!tone_active |=> tone_sample == 9'h100)
    else $error("sample not at mid level while silent");
  chk_ready_clear: assert property (status_read && !tx_done |=> !tx_ready)
    else $error("status read did not clear transmit ready");
  chk_tx_irq: assert property (tx_done |=> irq_pend)
    else $error("end of burst raised no interrupt");
endmodule : dtmf_core

// ==== verification/host_model.sv ====
// Purpose: Host model that reaches the core registers over single-word AHB-Lite transfers.
// Assumes: One slave on the bus, so its hreadyout serves as hready.
// Notes: Signals take blocking defaults at time zero, then change by non-blocking assignment just after a rising edge.
`timescale 1ns/1ps
module host_model
  import dtmf_pkg::*;
(
  input wire logic clk, // System clock.
  output logic hsel, // Slave select.
  output logic [31:0] haddr, // Address.
  output logic [1:0] htrans, // Transfer type.
  output logic hwrite, // Write strobe.
  output logic [2:0] hsize, // Transfer size, always a word.
  output logic [31:0] hwdata, // Write data.
  input wire logic hready, // Bus ready.
  input wire logic [31:0] hrdata // Read data.
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
  end

  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask : xfer

  // Burst mode stays off; the host sets the tone length by toggling the transmitter.
  task automatic timed_tone(input int n);
    logic [31:0] rd;
    xfer(ADDR_CTRL, 1'b1, 32'h00000001, rd);
    repeat (n) @(posedge clk);
    xfer(ADDR_CTRL, 1'b1, 32'h00000000, rd);
  endtask : timed_tone
endmodule : host_model

// ==== verification/dtmf_steering_and_tone_burst_tb.sv ====
// Purpose: Self-checking bench for the steering, status, shared pin and tone burst core.
// Assumes: Short burst counts and small guard counts keep the run brief.
// Notes: The shared pin level is worked out here from its pull-down enable and a pull-up.
`timescale 1ns/1ps
`define CHK(n, e, g) check(n, 32'(e), 32'(g))
module dtmf_steering_and_tone_burst_tb;
  import dtmf_pkg::*;
  localparam int BC = 40;
  localparam int BCP = 80;
  logic clk, nrst, tones_valid, cp_square, cp_inband, hsel, hwrite, hreadyout, hresp;
  logic early_steer, guard_drive_out, guard_oe_n, pin_out, pin_oe_n, tone_active;
  logic [3:0] det_code, rx_code_bits, c;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [31:0] seed = 32'hA8208BA0;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [SAMPLE_W:0] tone_sample;
  int err_count = 0;
  int compares = 0;
  int nz = 0;
  wire irq_level = pin_oe_n ? 1'b1 : pin_out;

  dtmf_core #(.BURST_CYCLES(BC), .BURST_CP_CYCLES(BCP)) dtmf_core_i (.clk(clk), .nrst(nrst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .tones_valid(tones_valid), .det_code(det_code),
    .cp_square(cp_square), .cp_inband(cp_inband), .early_steer(early_steer), .guard_drive_out(guard_drive_out),
    .guard_oe_n(guard_oe_n), .rx_code_bits(rx_code_bits), .interrupt_or_tone_out(pin_out),
    .interrupt_or_tone_oe_n(pin_oe_n), .tone_sample(tone_sample), .tone_active(tone_active));
  host_model host_model_i (.clk(clk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Keypad position to code: 0 is zero, 1-9 digits, 10 star, 11 hash, 12-14 A-C, 15 D.
  function automatic logic [3:0] digit_code(input logic [3:0] d);
    if (d == 4'h0) digit_code = 4'hA;
    else if (d <= 4'h9) digit_code = d;
    else if (d == 4'hF) digit_code = 4'h0;
    else digit_code = d + 4'h1;
  endfunction : digit_code

  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : check

  task automatic end_of_test();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] t;
    host_model_i.xfer(a, 1'b1, d, t);
  endtask : wr

  task automatic rdr(input logic [7:0] a);
    host_model_i.xfer(a, 1'b0, 32'h00000000, rd);
  endtask : rdr

  task automatic digit(input logic [3:0] code, input logic irq_on);
    tones_valid <= 1'b1;
    det_code <= code;
    repeat (2) @(posedge clk);
    `CHK("early steer", 1, early_steer);
    repeat (25) @(posedge clk);
    `CHK("rx code", code, rx_code_bits);
    `CHK("guard drive", 1, guard_drive_out);
    `CHK("guard pin driven", 0, guard_oe_n);
    `CHK("irq pin", !irq_on, irq_level);
    rdr(ADDR_STATUS);
    `CHK("status flags", 3'b110, rd[3:1]);
    if (irq_on) `CHK("irq pending", 1, rd[STAT_IRQ_PENDING]);
    rdr(ADDR_STATUS);
    `CHK("status cleared", 2'b10, rd[3:2]);
    @(posedge clk);
    `CHK("irq released", 1, irq_level);
    rdr(ADDR_RXDATA);
    `CHK("rx read", code, rd);
    tones_valid <= 1'b0;
    repeat (2) @(posedge clk);
    tones_valid <= 1'b1;
    repeat (10) @(posedge clk);
    rdr(ADDR_STATUS);
    `CHK("dropout kept", 1, rd[STAT_DELAYED_STEER]);
    tones_valid <= 1'b0;
    repeat (30) @(posedge clk);
    rdr(ADDR_STATUS);
    `CHK("pause valid", 0, rd[STAT_DELAYED_STEER]);
    `CHK("guard released", 0, guard_drive_out);
    `CHK("rx retained", code, rx_code_bits);
    tones_valid <= 1'b1;
    det_code <= code ^ 4'h1;
    repeat (3) @(posedge clk);
    tones_valid <= 1'b0;
    repeat (30) @(posedge clk);
    `CHK("short tone", code, rx_code_bits);
  endtask : digit

  task automatic burst_one(input logic [3:0] code, input int len);
    int n;
    n = 0;
    wr(ADDR_TXDATA, {28'h0000000, code});
    while (tone_active !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    n = 0;
    while (tone_active === 1'b1) begin
      @(posedge clk);
      n++;
    end
    `CHK("burst length", len, n);
    rdr(ADDR_STATUS);
    `CHK("ready in pause", 0, rd[STAT_TX_READY]);
    repeat (len) @(posedge clk);
    rdr(ADDR_STATUS);
    `CHK("ready after pause", 1, rd[STAT_TX_READY]);
  endtask : burst_one

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    end_of_test();
  end

  initial begin
    nrst = 1'b0;
    tones_valid = 1'b0;
    det_code = 4'h0;
    cp_square = 1'b0;
    cp_inband = 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    `CHK("reset rx", 0, rx_code_bits);
    `CHK("reset sample", 9'h100, tone_sample);
    rdr(ADDR_CTRL);
    `CHK("ctrl reset", CTRL_RESET, rd);
    rdr(ADDR_GUARD_PRESENT);
    `CHK("guard reset", GUARD_PRESENT_RESET, rd);
    rdr(8'h20);
    `CHK("unmapped", 0, rd);
    `CHK("hresp", 0, hresp);
    wr(ADDR_GUARD_PRESENT, 32'h00000005);
    wr(ADDR_GUARD_ABSENT, 32'h00000005);
    rdr(ADDR_GUARD_ABSENT);
    `CHK("guard write", 5, rd);
    for (int i = 0; i < 2; i++) begin
      seed = lfsr(seed);
      c = digit_code(seed[3:0]);
      wr(ADDR_CTRL, (i == 0) ? 32'h00000004 : 32'h00000000);
      digit(c, i == 0);
    end
    wr(ADDR_CTRL, 32'h00000002);
    tones_valid <= 1'b1;
    det_code <= ~c;
    repeat (30) @(posedge clk);
    `CHK("cp no steer", 0, early_steer);
    `CHK("cp no rx", c, rx_code_bits);
    for (int k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      cp_square <= seed[0];
      cp_inband <= seed[1];
      repeat (3) @(posedge clk);
      `CHK("cp pin", seed[0] & seed[1], irq_level);
    end
    wr(ADDR_CTRL, 32'h0000000B);
    burst_one(c, BCP);
    `CHK("cp burst no rx", 0, early_steer);
    tones_valid <= 1'b0;
    wr(ADDR_CTRL, 32'h00000009);
    for (int k = 0; k < 16; k++) burst_one(4'(k), BC);
    wr(ADDR_CTRL, 32'h00000000);
    fork
      host_model_i.timed_tone(400);
      repeat (420) begin
        @(posedge clk);
        if (tone_active === 1'b1 && tone_sample !== 9'h100) nz++;
      end
    join
    repeat (3) @(posedge clk);
    `CHK("tone moves", 1, nz > 0);
    `CHK("tone stopped", 0, tone_active);
    `CHK("silent sample", 9'h100, tone_sample);
    end_of_test();
  end
endmodule : dtmf_steering_and_tone_burst_tb
